// [src/hce_top.sv]
// setup word and host request checker, top level
`timescale 1ns/10ps
module hce_top
  import hce_pkg::*;
#(
  parameter logic [7:0] SCRN_MAX = 8'h03, // largest screen size code
  parameter logic [7:0] TMODE_MAX = 8'h01 // largest terminal mode code
) (
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // setup words and their check strobe
  input logic setup_check,
  input hce_setup_t setup,
  // host transfer or interrupt request
  input logic req_valid,
  input hce_req_t req,
  // interrupt hook registration
  input logic hook_valid,
  input logic [7:0] hook_num,
  // forced error from software
  input logic force_valid,
  input logic [15:0] force_code,
  // status read, clears the held code
  input logic status_read,
  // error status
  output logic err_flag,
  output logic [15:0] err_code,
  output logic err_pending
);

  // ---- setup word checks ----

  // boot program: BCD and no higher than 04
  wire s_boot_bad = !is_bcd(setup.boot_prog) ||
    (setup.boot_prog > BOOT_MAX);

  // flash automatic transfer: off or on key only
  wire s_flash_bad = !is_key(setup.flash_auto);

  // start mode: off or on key only
  wire s_start_bad = !is_key(setup.start_mode);

  // initial value transfer: BCD 0 or 1
  wire s_init_bad = setup.init_xfer > INIT_MAX;

  // reserved word must stay zero
  wire s_resv_bad = setup.resv != SET_OFF;

  // baud codes for the three ports
  wire s_baud1_bad = !is_bcd(setup.baud1) ||
    (setup.baud1 > BAUD_MAX);
  wire s_baud2_bad = !is_bcd(setup.baud2) ||
    (setup.baud2 > BAUD_MAX);
  wire s_baudt_bad = !is_bcd(setup.baud_term) ||
    (setup.baud_term > BAUD_MAX);
  wire s_baud_bad = s_baud1_bad || s_baud2_bad || s_baudt_bad;

  // words per cycle: off or on key only
  wire s_wpc_bad = !is_key(setup.wpc);

  // screen size and terminal mode against limits
  wire s_scrn_bad = (setup.scrn_size > SCRN_MAX) ||
    (setup.term_mode > TMODE_MAX);

  // area first words: 00 or BCD 10-99
  wire s_rd_bad = (setup.rd_first != SET_OFF) &&
    (!is_bcd(setup.rd_first) || (setup.rd_first < AREA_MIN));
  wire s_wr_bad = (setup.wr_first != SET_OFF) &&
    (!is_bcd(setup.wr_first) || (setup.wr_first < AREA_MIN));
  wire s_area_bad = s_rd_bad || s_wr_bad;

  // DMA options for both serial ports
  wire s_dma_bad = !is_key(setup.dma1) ||
    !is_key(setup.dma2);

  // only the lowest code is reported when several settings are bad
  logic [15:0] s_code;
  always_comb begin
    if (s_boot_bad) begin
      s_code = ERR_BOOT;
    end else if (s_flash_bad) begin
      s_code = ERR_FLASH;
    end else if (s_start_bad) begin
      s_code = ERR_START;
    end else if (s_init_bad) begin
      s_code = ERR_INIT;
    end else if (s_resv_bad) begin
      s_code = ERR_RESV;
    end else if (s_baud_bad) begin
      s_code = ERR_BAUD;
    end else if (s_wpc_bad) begin
      s_code = ERR_WPC;
    end else if (s_scrn_bad) begin
      s_code = ERR_SCRN;
    end else if (s_area_bad) begin
      s_code = ERR_AREA;
    end else if (s_dma_bad) begin
      s_code = ERR_DMA;
    end else begin
      s_code = ERR_NONE;
    end
  end

  // setup check raises an event only when a setting is bad
  wire s_fail = s_code != ERR_NONE;
  wire s_event = setup_check && s_fail;

  // ---- host request checks ----

  // request form
  wire r_is_ofs = (req.kind == REQ_OFS_READ) ||
    (req.kind == REQ_OFS_WRITE);
  wire r_is_bulk = (req.kind == REQ_BULK_READ) ||
    (req.kind == REQ_BULK_WRITE);
  wire r_is_int = req.kind == REQ_INT;
  wire r_is_rd = (req.kind == REQ_OFS_READ);

  // unknown kind, bad operand flag or empty transfer
  wire r_oper_bad = !(r_is_ofs || r_is_bulk || r_is_int) ||
    ((r_is_ofs || r_is_bulk) &&
    (!req.opnd_ok || (req.count == 8'h00)));

  // word count limit depends on the form
  wire r_count_bad = (r_is_ofs && (req.count > LIM_OFS)) ||
    (r_is_bulk && (req.count > LIM_BULK));

  // area start that the offset is measured from
  wire [7:0] r_area = r_is_rd ? setup.rd_first : setup.wr_first;

  // first word counted in binary, nine bits so no wrap
  wire [8:0] r_first = {1'b0, bcd_val(r_area)} +
    {1'b0, bcd_val(req.offset)};

  // offset must be BCD and land inside a configured area
  wire r_ofs_bad = r_is_ofs && ((r_area == SET_OFF) ||
    !is_bcd(req.offset) ||
    (r_first > {1'b0, AREA_TOP}));

  // interrupt number lookup in the hook table
  wire r_hit;

  // digits first, then range, then registration
  wire r_int_nbcd = r_is_int && !is_bcd(req.int_num);
  wire r_int_zero = r_is_int && (req.int_num < HOOK_MIN);
  wire r_int_miss = r_is_int && !r_hit;

  // request code, operand fault ranks highest
  logic [15:0] r_code;
  always_comb begin
    if (r_oper_bad) begin
      r_code = ERR_OPER;
    end else if (r_count_bad) begin
      r_code = ERR_COUNT;
    end else if (r_ofs_bad) begin
      r_code = ERR_OFS;
    end else if (r_int_nbcd) begin
      r_code = ERR_HBCD;
    end else if (r_int_zero) begin
      r_code = ERR_HRANGE;
    end else if (r_int_miss) begin
      r_code = ERR_NOHOOK;
    end else begin
      r_code = ERR_NONE;
    end
  end
  wire r_event = req_valid && (r_code != ERR_NONE);

  // ---- hook registration checks ----

  // a number is only stored when both digits and range are good
  wire h_nbcd = !is_bcd(hook_num);
  wire h_zero = hook_num < HOOK_MIN;
  wire h_store = hook_valid && !h_nbcd && !h_zero;
  wire [15:0] h_code = h_nbcd ? ERR_HBCD : ERR_HRANGE;
  wire h_event = hook_valid && (h_nbcd || h_zero);

  // registered numbers, searched with the request number
  hce_hook_table u_hooks (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(h_store),
    .wr_num(hook_num),
    .look_num(req.int_num),
    .hit(r_hit)
  );

  // ---- event selection ----

  // forced code goes first so software can always inject one;
  // lower sources in the same cycle are dropped, not queued,
  // since the holder keeps only one code anyway
  wire ev_valid = force_valid || s_event || r_event || h_event;
  wire [15:0] ev_code = force_valid ? force_code :
    s_event ? s_code :
    r_event ? r_code : h_code;

  // holder of the reported code
  hce_err_hold u_hold (
    .clk(clk),
    .sys_rst(sys_rst),
    .ev_valid(ev_valid),
    .ev_code(ev_code),
    .clr(status_read),
    .flag_r(err_flag),
    .code_r(err_code),
    .pending_r(err_pending)
  );

  // ---- checks on the logic above ----

  // helper: a request that no higher source masks
  wire req_sole = req_valid && !force_valid && !s_event;

  // helper: a registration that nothing else masks
  wire hook_sole = hook_valid && !force_valid && !s_event &&
    !r_event;

  // bad boot program is always the reported setup code
  a_boot_code: assert property (@(posedge clk) disable iff (sys_rst)
    setup_check && !force_valid &&
    (setup.boot_prog > BOOT_MAX) |=>
    err_flag && err_code == ERR_BOOT)
    else $error("boot program fault not reported as 0090");

  // clean setup alone raises nothing
  a_setup_clean: assert property (@(posedge clk) disable iff (sys_rst)
    setup_check && !s_fail && !force_valid && !req_valid &&
    !hook_valid |=> !err_flag)
    else $error("clean setup words raised an error");

  // nonzero reserved word after good earlier settings
  a_resv_code: assert property (@(posedge clk) disable iff (sys_rst)
    setup_check && !force_valid && !s_boot_bad && !s_flash_bad &&
    !s_start_bad && !s_init_bad && (setup.resv != SET_OFF) |=>
    err_code == ERR_RESV)
    else $error("reserved word fault not reported as 0094");

  // forced code comes out unchanged one cycle later
  a_force_code: assert property (@(posedge clk) disable iff (sys_rst)
    force_valid |=> err_flag && err_pending &&
    err_code == $past(force_code))
    else $error("forced code not reported");

  // empty bulk transfer gives operand fault
  a_oper_code: assert property (@(posedge clk) disable iff (sys_rst)
    req_sole && r_is_bulk && (req.count == 8'h00) |=>
    err_code == ERR_OPER)
    else $error("empty transfer not reported as 0800");

  // offset form over 90 words
  a_count_ofs: assert property (@(posedge clk) disable iff (sys_rst)
    req_sole && r_is_ofs && req.opnd_ok &&
    (req.count > LIM_OFS) |=> err_code == ERR_COUNT)
    else $error("offset transfer over limit not reported");

  // bulk form up to 128 words passes
  a_count_bulk: assert property (@(posedge clk) disable iff (sys_rst)
    req_sole && r_is_bulk && req.opnd_ok && (req.count != 8'h00) &&
    (req.count <= LIM_BULK) && !force_valid && !hook_valid |=>
    !err_flag)
    else $error("legal bulk transfer flagged");

  // offset into an unset area
  a_ofs_unset: assert property (@(posedge clk) disable iff (sys_rst)
    req_sole && r_is_ofs && req.opnd_ok && (req.count != 8'h00) &&
    (req.count <= LIM_OFS) && (r_area == SET_OFF) |=>
    err_code == ERR_OFS)
    else $error("offset into unset area not reported");

  // interrupt number with a bad digit
  a_int_nbcd: assert property (@(posedge clk) disable iff (sys_rst)
    req_sole && r_is_int && (req.int_num[3:0] > 4'h9) |=>
    err_code == ERR_HBCD)
    else $error("bad interrupt digit not reported");

  // legal number that was never registered
  a_int_miss: assert property (@(posedge clk) disable iff (sys_rst)
    req_sole && r_is_int && is_bcd(req.int_num) &&
    (req.int_num != 8'h00) && !r_hit |=>
    err_code == ERR_NOHOOK)
    else $error("unregistered interrupt not reported");

  // registration of number zero
  a_hook_range: assert property (@(posedge clk) disable iff (sys_rst)
    hook_sole && (hook_num == 8'h00) |=>
    err_flag && err_code == ERR_HRANGE)
    else $error("hook number zero not reported as 0085");

  // stored hook is found on the following request
  a_hook_found: assert property (@(posedge clk) disable iff (sys_rst)
    h_store && !force_valid && !setup_check ##1
    (req_valid && r_is_int && req.int_num == $past(hook_num) &&
    !force_valid && !setup_check && !hook_valid) |=> !err_flag)
    else $error("registered hook not matched");

  // baud fault on terminal port after clean earlier words
  a_baud_term: assert property (@(posedge clk) disable iff (sys_rst)
    setup_check && !force_valid && !s_boot_bad && !s_flash_bad &&
    !s_start_bad && !s_init_bad && !s_resv_bad &&
    (setup.baud_term == 8'h09) |=> err_code == ERR_BAUD)
    else $error("terminal baud fault not reported as 0095");

  // helper: every setup word ranked above words per cycle is clean
  wire s_pre_wpc = !s_boot_bad && !s_flash_bad && !s_start_bad &&
    !s_init_bad && !s_resv_bad && !s_baud_bad;

  // start mode outside both keys after clean boot and flash words
  a_start_code: assert property (@(posedge clk) disable iff (sys_rst)
    setup_check && !force_valid && !s_boot_bad && !s_flash_bad &&
    (setup.start_mode != SET_OFF) && (setup.start_mode != SET_ON) |=>
    err_flag && err_code == ERR_START)
    else $error("start mode fault not reported as 0092");

  // initial transfer above one after clean earlier words
  a_init_code: assert property (@(posedge clk) disable iff (sys_rst)
    setup_check && !force_valid && !s_boot_bad && !s_flash_bad &&
    !s_start_bad && (setup.init_xfer > INIT_MAX) |=>
    err_flag && err_code == ERR_INIT)
    else $error("initial transfer fault not reported as 0093");

  // words per cycle outside both keys
  a_wpc_code: assert property (@(posedge clk) disable iff (sys_rst)
    setup_check && !force_valid && s_pre_wpc &&
    (setup.wpc != SET_OFF) && (setup.wpc != SET_ON) |=>
    err_flag && err_code == ERR_WPC)
    else $error("words per cycle fault not reported as 0096");

  // screen size beyond its limit
  a_scrn_code: assert property (@(posedge clk) disable iff (sys_rst)
    setup_check && !force_valid && s_pre_wpc && !s_wpc_bad &&
    (setup.scrn_size > SCRN_MAX) |=> err_flag && err_code == ERR_SCRN)
    else $error("screen size fault not reported as 0097");

  // read area starting below word 10
  a_area_code: assert property (@(posedge clk) disable iff (sys_rst)
    setup_check && !force_valid && s_pre_wpc && !s_wpc_bad &&
    !s_scrn_bad && (setup.rd_first != SET_OFF) &&
    (setup.rd_first < AREA_MIN) |=> err_flag && err_code == ERR_AREA)
    else $error("area start fault not reported as 0098");

  // first port DMA option outside both keys
  a_dma_code: assert property (@(posedge clk) disable iff (sys_rst)
    setup_check && !force_valid && s_pre_wpc && !s_wpc_bad &&
    !s_scrn_bad && !s_area_bad && (setup.dma1 != SET_OFF) &&
    (setup.dma1 != SET_ON) |=> err_flag && err_code == ERR_DMA)
    else $error("DMA option fault not reported as 0099");

  // registration with an illegal units digit
  a_hook_nbcd: assert property (@(posedge clk) disable iff (sys_rst)
    hook_sole && (hook_num[3:0] > 4'h9) |=>
    err_flag && err_code == ERR_HBCD)
    else $error("bad hook digit not reported as 0086");

endmodule

// [include/hce_pkg.sv]
// shared types and constants for the host setup and request checker
// Notes on behaviour
// - boot program number must be BCD 00-04
// - flash auto transfer must be 00 or 5A
// - start mode must be 00 or 5A
// - initial value transfer must be BCD 0/1
// - reserved setup word must be zero
// - each port baud code must be BCD 00-08
// - words per cycle must be 00 or 5A
// - screen size and terminal mode in range
// - area first word 00 or BCD 10-99
// - port DMA options must be 00 or 5A
// - malformed read/write operands give 0800
// - word count limit 90 offset, 128 bulk
// - interrupt number must match a registered hook
// - offset must fit the configured area start
// - registered hook number must be 01-99
// - interrupt number digits must be legal BCD
// - forced code handled like detected error
package hce_pkg;

  // error codes, BCD as reported to software
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_OPER = 16'h0800;
  localparam logic [15:0] ERR_COUNT = 16'h0081;
  localparam logic [15:0] ERR_NOHOOK = 16'h0082;
  localparam logic [15:0] ERR_OFS = 16'h0083;
  localparam logic [15:0] ERR_HRANGE = 16'h0085;
  localparam logic [15:0] ERR_HBCD = 16'h0086;
  localparam logic [15:0] ERR_BOOT = 16'h0090;
  localparam logic [15:0] ERR_FLASH = 16'h0091;
  localparam logic [15:0] ERR_START = 16'h0092;
  localparam logic [15:0] ERR_INIT = 16'h0093;
  localparam logic [15:0] ERR_RESV = 16'h0094;
  localparam logic [15:0] ERR_BAUD = 16'h0095;
  localparam logic [15:0] ERR_WPC = 16'h0096;
  localparam logic [15:0] ERR_SCRN = 16'h0097;
  localparam logic [15:0] ERR_AREA = 16'h0098;
  localparam logic [15:0] ERR_DMA = 16'h0099;

  // setting values and limits
  localparam logic [7:0] SET_OFF = 8'h00;
  localparam logic [7:0] SET_ON = 8'h5A;
  localparam logic [7:0] BOOT_MAX = 8'h04;
  localparam logic [7:0] INIT_MAX = 8'h01;
  localparam logic [7:0] BAUD_MAX = 8'h08;
  localparam logic [7:0] AREA_MIN = 8'h10;
  localparam logic [7:0] HOOK_MIN = 8'h01;
  localparam logic [7:0] LIM_OFS = 8'h5A; // 90 words
  localparam logic [7:0] LIM_BULK = 8'h80; // 128 words
  localparam logic [7:0] AREA_TOP = 8'h63; // word 99 binary
  localparam int HOOK_DEPTH = 8;
  localparam logic [2:0] HOOK_PTR_RST = 3'h0;

  // request kinds from the host
  typedef enum logic [2:0] {
    REQ_OFS_READ,
    REQ_OFS_WRITE,
    REQ_BULK_READ,
    REQ_BULK_WRITE,
    REQ_INT
  } hce_kind_t;

  // setup words as read from the host area
  typedef struct packed {
    logic [7:0] boot_prog;
    logic [7:0] flash_auto;
    logic [7:0] start_mode;
    logic [7:0] init_xfer;
    logic [7:0] resv;
    logic [7:0] baud1;
    logic [7:0] baud2;
    logic [7:0] baud_term;
    logic [7:0] wpc;
    logic [7:0] scrn_size;
    logic [7:0] term_mode;
    logic [7:0] rd_first;
    logic [7:0] wr_first;
    logic [7:0] dma1;
    logic [7:0] dma2;
  } hce_setup_t;

  // one host transfer or interrupt request
  typedef struct packed {
    hce_kind_t kind;
    logic opnd_ok;
    logic [7:0] offset;
    logic [7:0] count;
    logic [7:0] int_num;
  } hce_req_t;

  // both digits legal BCD
  function automatic logic is_bcd(input logic [7:0] b);
    is_bcd = (b[7:4] < 4'hA) && (b[3:0] < 4'hA);
  endfunction

  // only the off or on pattern allowed
  function automatic logic is_key(input logic [7:0] b);
    is_key = (b == SET_OFF) || (b == SET_ON);
  endfunction

  // BCD byte to binary, valid only for legal BCD
  function automatic logic [7:0] bcd_val(input logic [7:0] b);
    bcd_val = {4'h0, b[7:4]} * 8'h0A + {4'h0, b[3:0]};
  endfunction

endpackage

// [src/hce_hook_table.sv]
// table of registered host interrupt hook numbers
`timescale 1ns/10ps
module hce_hook_table
  import hce_pkg::*;
(
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // registration side
  input logic wr_en,
  input logic [7:0] wr_num,
  // lookup side
  input logic [7:0] look_num,
  output logic hit
);

  // stored numbers and their valid marks
  logic [7:0] num_r [HOOK_DEPTH];
  logic [HOOK_DEPTH-1:0] vld_r;
  logic [2:0] ptr_r;
  logic [HOOK_DEPTH-1:0] match;

  // compare every slot at once
  always_comb begin
    for (int i = 0; i < HOOK_DEPTH; i++) begin
      match[i] = vld_r[i] && (num_r[i] == look_num);
    end
  end
  assign hit = |match;

  // oldest slot is overwritten once the table is full
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vld_r <= '0;
      ptr_r <= HOOK_PTR_RST;
    end else if (wr_en) begin
      num_r[ptr_r] <= wr_num;
      vld_r[ptr_r] <= 1'b1;
      ptr_r <= ptr_r + 3'h1;
    end
  end

endmodule

// [src/hce_err_hold.sv]
// holder of the last flagged error code
`timescale 1ns/10ps
module hce_err_hold
  import hce_pkg::*;
(
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // new event and read clear
  input logic ev_valid,
  input logic [15:0] ev_code,
  input logic clr,
  // status: one-cycle flag, held code and pending
  output logic flag_r,
  output logic [15:0] code_r,
  output logic pending_r
);

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
      code_r <= ERR_NONE;
      pending_r <= 1'b0;
    end else begin
      flag_r <= ev_valid;
      if (ev_valid) begin
        code_r <= ev_code;
        pending_r <= 1'b1;
      end else if (clr) begin
        code_r <= ERR_NONE;
        pending_r <= 1'b0;
      end
    end
  end

  // code stays put while nothing touches it
  a_hold_stable: assert property (@(posedge clk) disable iff (sys_rst)
    pending_r && !ev_valid && !clr |=> $stable(code_r) && pending_r)
    else $error("held error code changed without cause");

  // set wins over clear
  a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    ev_valid && clr |=> pending_r && code_r == $past(ev_code))
    else $error("clear beat a new error event");

endmodule

// [tb/hce_host_model.sv]
// host controller model: supplies a legal image of the setup words
`timescale 1ns/10ps
module hce_host_model
  import hce_pkg::*;
(
  // legal setup image, driven constantly
  output hce_setup_t good
);
  // boundary values where a range allows, so the legal edge gets tested too
  assign good.boot_prog = 8'h04;
  assign good.flash_auto = 8'h5A;
  assign good.start_mode = 8'h5A;
  assign good.init_xfer = 8'h01;
  assign good.resv = 8'h00;
  assign good.baud1 = 8'h08;
  assign good.baud2 = 8'h00;
  assign good.baud_term = 8'h08;
  assign good.wpc = 8'h5A;
  assign good.scrn_size = 8'h03;
  assign good.term_mode = 8'h01;
  // areas start at word 10, so offsets 00 to 89 still fit up to word 99
  assign good.rd_first = 8'h10;
  assign good.wr_first = 8'h10;
  assign good.dma1 = 8'h5A;
  assign good.dma2 = 8'h00;
endmodule

// [tb/tb.sv]
// self-checking bench for the setup word and host request checker
`timescale 1ns/10ps
module tb;
  import hce_pkg::*;
  // stimulus, all given a value at time zero
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic setup_check = 1'b0;
  hce_setup_t setup = '0;
  logic req_valid = 1'b0;
  hce_req_t req = '0;
  logic hook_valid = 1'b0;
  logic [7:0] hook_num = 8'h00;
  logic force_valid = 1'b0;
  logic [15:0] force_code = 16'h0000;
  logic status_read = 1'b0;
  // design outputs and the host image
  logic err_flag;
  logic [15:0] err_code;
  logic err_pending;
  hce_setup_t good;
  // score keeping
  int error_cnt = 0;
  int check_count = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  hce_top #(.SCRN_MAX(8'h03), .TMODE_MAX(8'h01)) i_hce_top (
    .clk(clk), .sys_rst(sys_rst), .setup_check(setup_check),
    .setup(setup), .req_valid(req_valid), .req(req),
    .hook_valid(hook_valid), .hook_num(hook_num),
    .force_valid(force_valid), .force_code(force_code),
    .status_read(status_read), .err_flag(err_flag),
    .err_code(err_code), .err_pending(err_pending)
  );

  hce_host_model i_hce_host_model (.good(good));

  // compare one value, four-state exact
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // pass the taking edge, drop strobes, judge the one-cycle answer
  task automatic run(input logic [15:0] exp);
    @(posedge clk);
    @(negedge clk);
    {setup_check, req_valid, hook_valid, force_valid} = 4'h0;
    chk("err_flag", {15'h0, exp != ERR_NONE}, {15'h0, err_flag});
    chk("err_code", exp, err_code);
    chk("err_pending", {15'h0, exp != ERR_NONE}, {15'h0, err_pending});
    // read back clears, so the next case starts from an empty holder
    if (exp != ERR_NONE) begin
      status_read = 1'b1;
      @(posedge clk);
      @(negedge clk);
      status_read = 1'b0;
      chk("cleared code", ERR_NONE, err_code);
      chk("cleared pending", 16'h0, {15'h0, err_pending});
    end else begin
      // idle edge, so a strobe is never dropped and raised at once
      @(negedge clk);
    end
  endtask

  task automatic send_req(input hce_kind_t k, input logic ok,
    input logic [7:0] ofs, input logic [7:0] cnt, input logic [7:0] num,
    input logic [15:0] exp);
    req = '{k, ok, ofs, cnt, num};
    req_valid = 1'b1;
    run(exp);
  endtask

  task automatic hook(input logic [7:0] n, input logic [15:0] exp);
    hook_num = n;
    hook_valid = 1'b1;
    run(exp);
  endtask

  // one bad field at a time, then priority and legal boundaries
  task automatic t_setup();
    hce_setup_t s;
    logic [15:0] e;
    for (int i = 0; i < 18; i++) begin
      s = good;
      e = ERR_NONE;
      case (i)
        0: begin s.boot_prog = 8'h05; e = ERR_BOOT; end
        1: begin s.boot_prog = 8'h0A; e = ERR_BOOT; end
        2: begin s.flash_auto = 8'h01; e = ERR_FLASH; end
        3: begin s.start_mode = 8'h5B; e = ERR_START; end
        4: begin s.init_xfer = 8'h02; e = ERR_INIT; end
        5: begin s.resv = 8'h01; e = ERR_RESV; end
        6: begin s.baud1 = 8'h09; e = ERR_BAUD; end
        7: begin s.baud2 = 8'h0A; e = ERR_BAUD; end
        8: begin s.baud_term = 8'h10; e = ERR_BAUD; end
        9: begin s.wpc = 8'hA5; e = ERR_WPC; end
        10: begin s.scrn_size = 8'h04; e = ERR_SCRN; end
        11: begin s.term_mode = 8'h02; e = ERR_SCRN; end
        12: begin s.rd_first = 8'h09; e = ERR_AREA; end
        13: begin s.wr_first = 8'h1A; e = ERR_AREA; end
        14: begin s.dma1 = 8'h01; e = ERR_DMA; end
        15: begin s.dma2 = 8'hA5; e = ERR_DMA; end
        16: begin s.boot_prog = 8'h0F; s.dma1 = 8'h01; e = ERR_BOOT; end
        17: begin s.rd_first = 8'h00; s.wr_first = 8'h99; s.wpc = 8'h00; end
        default: begin end
      endcase
      setup = s;
      setup_check = 1'b1;
      run(e);
    end
    setup = good;
    $display("test setup done");
  endtask

  // operand, count and offset checks; areas start at word 10
  task automatic t_req();
    send_req(REQ_OFS_READ, 1'b0, 8'h00, 8'h01, 8'h00, ERR_OPER);
    send_req(REQ_BULK_WRITE, 1'b1, 8'h00, 8'h00, 8'h00, ERR_OPER);
    send_req(hce_kind_t'(3'h7), 1'b1, 8'h00, 8'h01, 8'h00, ERR_OPER);
    send_req(REQ_OFS_READ, 1'b1, 8'h00, 8'h5A, 8'h00, ERR_NONE);
    send_req(REQ_OFS_WRITE, 1'b1, 8'h00, 8'h5B, 8'h00, ERR_COUNT);
    send_req(REQ_BULK_READ, 1'b1, 8'h00, 8'h80, 8'h00, ERR_NONE);
    send_req(REQ_BULK_WRITE, 1'b1, 8'h00, 8'h81, 8'h00, ERR_COUNT);
    send_req(REQ_OFS_WRITE, 1'b1, 8'h89, 8'h01, 8'h00, ERR_NONE);
    send_req(REQ_OFS_READ, 1'b1, 8'h90, 8'h01, 8'h00, ERR_OFS);
    send_req(REQ_OFS_WRITE, 1'b1, 8'h1A, 8'h01, 8'h00, ERR_OFS);
    // read area switched off: any offset read has nowhere to land
    setup.rd_first = SET_OFF;
    send_req(REQ_OFS_READ, 1'b1, 8'h00, 8'h01, 8'h00, ERR_OFS);
    setup = good;
    $display("test request done");
  endtask

  // registration and lookup of interrupt hook numbers
  task automatic t_hook();
    hook(8'h1A, ERR_HBCD);
    hook(8'h00, ERR_HRANGE);
    hook(8'h99, ERR_NONE);
    // register and request back to back, table answers next cycle
    hook_num = 8'h42;
    hook_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    hook_valid = 1'b0;
    chk("hook flag", 16'h0, {15'h0, err_flag});
    chk("hook code", ERR_NONE, err_code);
    chk("hook pending", 16'h0, {15'h0, err_pending});
    send_req(REQ_INT, 1'b1, 8'h00, 8'h00, 8'h42, ERR_NONE);
    send_req(REQ_INT, 1'b1, 8'h00, 8'h00, 8'h43, ERR_NOHOOK);
    send_req(REQ_INT, 1'b1, 8'h00, 8'h00, 8'h99, ERR_NONE);
    send_req(REQ_INT, 1'b1, 8'h00, 8'h00, 8'h00, ERR_HRANGE);
    send_req(REQ_INT, 1'b1, 8'h00, 8'h00, 8'hB1, ERR_HBCD);
    send_req(REQ_INT, 1'b1, 8'h00, 8'h00, 8'h3C, ERR_HBCD);
    $display("test hook done");
  endtask

  // forced codes, also against a bad setup word in the same cycle
  task automatic t_force();
    force_code = ERR_START;
    force_valid = 1'b1;
    run(ERR_START);
    setup.boot_prog = 8'h07;
    setup_check = 1'b1;
    force_code = 16'h0123;
    force_valid = 1'b1;
    run(16'h0123);
    setup = good;
    $display("test force done");
  endtask

  // code stands unread; a restart clears it and the hook table
  task automatic t_hold();
    hook(8'h55, ERR_NONE);
    force_code = ERR_DMA;
    force_valid = 1'b1;
    status_read = 1'b1;
    @(posedge clk);
    @(negedge clk);
    force_valid = 1'b0;
    status_read = 1'b0;
    repeat (5) @(negedge clk);
    chk("held flag", 16'h0, {15'h0, err_flag});
    chk("held code", ERR_DMA, err_code);
    chk("held pending", 16'h1, {15'h0, err_pending});
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk("restart code", ERR_NONE, err_code);
    chk("restart pending", 16'h0, {15'h0, err_pending});
    send_req(REQ_INT, 1'b1, 8'h00, 8'h00, 8'h55, ERR_NOHOOK);
    $display("test hold done");
  endtask

  // verdict, the single exit of the run
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence; one spare cycle after reset before the first setup check
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    setup = good;
    @(negedge clk);
    chk("reset code", ERR_NONE, err_code);
    t_setup();
    t_req();
    t_hook();
    t_force();
    t_hold();
    conclude();
  end

  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #(25 * 5000);
    error_cnt++;
    $display("mismatch watchdog expected done seen timeout");
    conclude();
  end
endmodule
